// file: src/cpu_opcode_cycle_decode.sv
// Opcode decode and bus cycle sequencer for index/stack, wait and addressing
module cpu_opcode_cycle_decode (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  bus_rdata,
  input  wire logic        irq_pin,
  input  wire logic [15:0] index_hx,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_kind,
  input  wire logic [7:0]  req_data,
  output logic      [15:0] bus_addr,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic      [7:0]  bus_wdata,
  output logic      [2:0]  cyc_type,
  output logic      [15:0] stack_ptr,
  output logic      [15:0] prog_ctr,
  output logic             irq_mask,
  output logic             halted,
  output logic             req_ack
);
  cyc_pkg::state_t state;
  cyc_pkg::state_t next_state;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic        next_mask;
  logic [15:0] next_addr;
  logic        next_rd;
  logic        next_wr;
  logic [7:0]  next_wdata;
  logic [2:0]  next_cyc;
  logic        next_ack;
  logic [1:0]  op_kind;
  logic [1:0]  next_op_kind;
  logic [7:0]  op_data;
  logic [7:0]  next_op_data;
  logic        irq_meta;
  logic        irq_sync;

  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [7:0]  off);
    rel_target = pc + {{8{off[7]}}, off};
  endfunction

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_pin;
      irq_sync <= irq_meta;
    end
  end

  always_comb begin
    next_state   = state;
    next_pc      = prog_ctr;
    next_sp      = stack_ptr;
    next_mask    = irq_mask;
    next_ack     = 1'b0;
    next_op_kind = op_kind;
    next_op_data = op_data;
    unique case (state)
      cyc_pkg::ST_FETCH: begin
        next_pc = prog_ctr + cyc_pkg::ONE16;
        if (bus_rdata == cyc_pkg::OP_IDX_TO_SP) begin
          next_state = cyc_pkg::ST_XFER_SP;
        end else if (bus_rdata == cyc_pkg::OP_WAIT_IRQ) begin
          next_state = cyc_pkg::ST_WFI;
        end else if (req_valid) begin
          next_state   = cyc_pkg::ST_OP;
          next_ack     = 1'b1;
          next_op_kind = req_kind;
          next_op_data = req_data;
        end
      end
      cyc_pkg::ST_XFER_SP: begin
        next_sp    = index_hx - cyc_pkg::ONE16;
        next_state = cyc_pkg::ST_FETCH;
      end
      cyc_pkg::ST_WFI: begin
        next_mask  = 1'b0;
        next_state = cyc_pkg::ST_HALT;
      end
      cyc_pkg::ST_HALT: begin
        if (irq_sync && !irq_mask) begin
          next_state = cyc_pkg::ST_PSH_L;
        end
      end
      cyc_pkg::ST_OP: begin
        next_state = cyc_pkg::ST_FETCH;
        if (op_kind == cyc_pkg::REQ_PUSH) begin
          next_sp = stack_ptr - cyc_pkg::ONE16;
        end else if (op_kind == cyc_pkg::REQ_BRANCH) begin
          next_pc = rel_target(prog_ctr, op_data);
        end
      end
      cyc_pkg::ST_PSH_L: begin
        next_sp    = stack_ptr - cyc_pkg::ONE16;
        next_state = cyc_pkg::ST_PSH_H;
      end
      cyc_pkg::ST_PSH_H: begin
        next_sp    = stack_ptr - cyc_pkg::ONE16;
        next_state = cyc_pkg::ST_VEC_H;
      end
      cyc_pkg::ST_VEC_H: begin
        next_pc    = {bus_rdata, prog_ctr[7:0]};
        next_mask  = 1'b1;
        next_state = cyc_pkg::ST_VEC_L;
      end
      cyc_pkg::ST_VEC_L: begin
        next_pc    = {prog_ctr[15:8], bus_rdata};
        next_state = cyc_pkg::ST_FETCH;
      end
      default: next_state = cyc_pkg::ST_FETCH;
    endcase
  end

  // Bus activity of the coming cycle, from its state
  always_comb begin
    next_addr  = next_pc;
    next_rd    = 1'b1;
    next_wr    = 1'b0;
    next_wdata = 8'h00;
    next_cyc   = cyc_pkg::CYC_FREE;
    unique case (next_state)
      cyc_pkg::ST_FETCH: next_cyc = cyc_pkg::CYC_FETCH;
      cyc_pkg::ST_OP: begin
        unique case (next_op_kind)
          cyc_pkg::REQ_PUSH: begin
            next_addr  = next_sp;
            next_rd    = 1'b0;
            next_wr    = 1'b1;
            next_wdata = next_op_data;
            next_cyc   = cyc_pkg::CYC_PUSH;
          end
          cyc_pkg::REQ_POP: begin
            next_addr = next_sp + cyc_pkg::ONE16;
            next_cyc  = cyc_pkg::CYC_POP;
          end
          cyc_pkg::REQ_DIRECT: begin
            next_addr = {cyc_pkg::DIRECT_PAGE, next_op_data};
            next_cyc  = cyc_pkg::CYC_OPREAD;
          end
          cyc_pkg::REQ_BRANCH: next_cyc = cyc_pkg::CYC_FREE;
        endcase
      end
      cyc_pkg::ST_PSH_L, cyc_pkg::ST_PSH_H: begin
        next_addr  = next_sp;
        next_rd    = 1'b0;
        next_wr    = 1'b1;
        next_wdata = (next_state == cyc_pkg::ST_PSH_L) ?
                     next_pc[7:0] : next_pc[15:8];
        next_cyc   = cyc_pkg::CYC_PUSH;
      end
      cyc_pkg::ST_VEC_H: begin
        next_addr = cyc_pkg::IRQ_VECTOR;
        next_cyc  = cyc_pkg::CYC_VECTOR;
      end
      cyc_pkg::ST_VEC_L: begin
        next_addr = cyc_pkg::IRQ_VECTOR + cyc_pkg::ONE16;
        next_cyc  = cyc_pkg::CYC_VECTOR;
      end
      default: next_cyc = cyc_pkg::CYC_FREE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= cyc_pkg::ST_FETCH;
      prog_ctr  <= cyc_pkg::RESET_PC;
      stack_ptr <= cyc_pkg::RESET_SP;
      irq_mask  <= cyc_pkg::RESET_IMASK;
      op_kind   <= cyc_pkg::REQ_PUSH;
      op_data   <= 8'h00;
      bus_addr  <= cyc_pkg::RESET_PC;
      bus_rd    <= 1'b1;
      bus_wr    <= 1'b0;
      bus_wdata <= 8'h00;
      cyc_type  <= cyc_pkg::CYC_FETCH;
      halted    <= 1'b0;
      req_ack   <= 1'b0;
    end else begin
      state     <= next_state;
      prog_ctr  <= next_pc;
      stack_ptr <= next_sp;
      irq_mask  <= next_mask;
      op_kind   <= next_op_kind;
      op_data   <= next_op_data;
      bus_addr  <= next_addr;
      bus_rd    <= next_rd;
      bus_wr    <= next_wr;
      bus_wdata <= next_wdata;
      cyc_type  <= next_cyc;
      halted    <= (next_state == cyc_pkg::ST_HALT);
      req_ack   <= next_ack;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_xfer_op;
    state == cyc_pkg::ST_FETCH && bus_rdata == cyc_pkg::OP_IDX_TO_SP;
  endsequence
  sequence s_wait_op;
    state == cyc_pkg::ST_FETCH && bus_rdata == cyc_pkg::OP_WAIT_IRQ;
  endsequence

  property p_xfer;
    s_xfer_op ##1 (cyc_type == cyc_pkg::CYC_FREE)
    |=> cyc_type == cyc_pkg::CYC_FETCH &&
        stack_ptr == $past(index_hx) - cyc_pkg::ONE16;
  endproperty
  a_xfer: assert property (p_xfer) else $error("index copy wrong");

  property p_wait;
    s_wait_op |-> ##2 (halted && !irq_mask);
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt");

  property p_free_no_write;
    cyc_type == cyc_pkg::CYC_FREE |-> bus_rd && !bus_wr;
  endproperty
  a_free_no_write: assert property (p_free_no_write)
    else $error("free cycle wrote");

  property p_free_read;
    s_xfer_op |=> bus_rd && cyc_type == cyc_pkg::CYC_FREE
    ##1 (cyc_type == cyc_pkg::CYC_FETCH && !halted);
  endproperty
  a_free_read: assert property (p_free_read)
    else $error("free cycle not one read");

  // Reset-held fetch and the first fetch are one bus cycle
  property p_fetch_seq;
    !rst && cyc_type == cyc_pkg::CYC_FETCH ##1 cyc_type == cyc_pkg::CYC_FETCH
    |-> bus_addr == $past(bus_addr) + cyc_pkg::ONE16;
  endproperty
  a_fetch_seq: assert property (p_fetch_seq)
    else $error("fetch not sequential");

  property p_push;
    cyc_type == cyc_pkg::CYC_PUSH |-> bus_wr && !bus_rd &&
                                      bus_addr == stack_ptr;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pop;
    cyc_type == cyc_pkg::CYC_POP |-> bus_rd && !bus_wr &&
                                     bus_addr == stack_ptr + cyc_pkg::ONE16;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_branch;
    state == cyc_pkg::ST_OP && op_kind == cyc_pkg::REQ_BRANCH
    |=> bus_addr == $past(prog_ctr) + {{8{$past(op_data[7])}},
                                        $past(op_data)};
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");

  property p_direct;
    cyc_type == cyc_pkg::CYC_OPREAD |->
      bus_addr[15:8] == cyc_pkg::DIRECT_PAGE && bus_addr[7:0] == op_data;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct page high byte set");

  property p_wake;
    halted && irq_sync && !irq_mask |=> ##2 cyc_type == cyc_pkg::CYC_VECTOR
                                    ##2 cyc_type == cyc_pkg::CYC_FETCH;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on irq");
endmodule // cpu_opcode_cycle_decode

// file: src/cyc_pkg.sv
// Constants for the opcode decode and bus cycle sequencer
package cyc_pkg;
  localparam logic [7:0]  OP_IDX_TO_SP = 8'h94;
  localparam logic [7:0]  OP_WAIT_IRQ  = 8'h8f;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] RESET_SP     = 16'h00ff;
  localparam logic [15:0] IRQ_VECTOR   = 16'hfff0;
  localparam logic [15:0] ONE16        = 16'h0001;
  localparam logic [7:0]  DIRECT_PAGE  = 8'h00;
  localparam logic        RESET_IMASK  = 1'b1;

  typedef enum logic [1:0] {
    REQ_PUSH   = 2'h0,
    REQ_POP    = 2'h1,
    REQ_DIRECT = 2'h2,
    REQ_BRANCH = 2'h3
  } req_kind_t;

  typedef enum logic [2:0] {
    CYC_FREE   = 3'h0,
    CYC_FETCH  = 3'h1,
    CYC_PUSH   = 3'h2,
    CYC_POP    = 3'h3,
    CYC_OPREAD = 3'h4,
    CYC_VECTOR = 3'h5
  } cyc_t;

  typedef enum logic [8:0] {
    ST_FETCH = 9'h001,
    ST_XFER_SP = 9'h002,
    ST_WFI   = 9'h004,
    ST_HALT  = 9'h008,
    ST_OP    = 9'h010,
    ST_PSH_L = 9'h020,
    ST_PSH_H = 9'h040,
    ST_VEC_H = 9'h080,
    ST_VEC_L = 9'h100
  } state_t;
endpackage

// file: testbench/sys_mem.sv
// Memory model answering the sequencer's bus cycles
module sys_mem (
  input  wire logic        ref_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  always @(posedge ref_clk) begin
    if (bus_wr) mem[bus_addr] <= bus_wdata;
    last <= bus_rdata;
  end
  // Released data lines show the inverse of the last byte
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~last;
endmodule // sys_mem

// file: testbench/tb.sv
// Self-checking bench for the opcode decode and bus cycle sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        irq_pin = 1'b0;
  logic [15:0] index_hx = 16'h0000;
  logic        req_valid = 1'b0;
  logic [1:0]  req_kind = 2'h0;
  logic [7:0]  req_data = 8'h00;
  logic [7:0]  bus_rdata, bus_wdata;
  logic [15:0] bus_addr, stack_ptr, prog_ctr, pc, sp;
  logic        bus_rd, bus_wr, irq_mask, halted, req_ack;
  logic [2:0]  cyc_type;
  logic [31:0] seed = 32'hbea9;
  int          n;
  int          error_cnt = 0;
  int          compares = 0;

  cpu_opcode_cycle_decode dut (
    .ref_clk(ref_clk), .rst(rst), .bus_rdata(bus_rdata),
    .irq_pin(irq_pin), .index_hx(index_hx), .req_valid(req_valid),
    .req_kind(req_kind), .req_data(req_data), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .cyc_type(cyc_type), .stack_ptr(stack_ptr), .prog_ctr(prog_ctr),
    .irq_mask(irq_mask), .halted(halted), .req_ack(req_ack)
  );
  sys_mem u_mem (
    .ref_clk(ref_clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata)
  );

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Served cycle: kind code and address expected
  function automatic logic [18:0] exp_cyc(input logic [1:0] k,
                                          input logic [7:0] d);
    case (k)
      2'h0: return {cyc_pkg::CYC_PUSH, sp};
      2'h1: return {cyc_pkg::CYC_POP, sp + 16'h1};
      2'h2: return {cyc_pkg::CYC_OPREAD, cyc_pkg::DIRECT_PAGE, d};
      default: return {cyc_pkg::CYC_FREE, 16'h0000};
    endcase
  endfunction

  task automatic req(input logic [1:0] k, input logic [7:0] d);
    logic [18:0] e;
    e = exp_cyc(k, d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_data <= d;
    #1;
    chk("fetch_addr", pc, bus_addr);
    chk("sp", sp, stack_ptr);
    chk("pc", pc, prog_ctr);
    chk("ack_drop", 16'h0, {15'h0, req_ack});
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    chk("ack", 16'h1, {15'h0, req_ack});
    chk("wr", {15'h0, k == 2'h0}, {15'h0, bus_wr});
    chk("cyc", {13'h0, e[18:16]}, {13'h0, cyc_type});
    if (k != 2'h3) chk("addr", e[15:0], bus_addr);
    if (k == 2'h0) chk("wdata", {8'h0, d}, {8'h0, bus_wdata});
    pc = pc + 16'h1 + ((k == 2'h3) ? {{8{d[7]}}, d} : 16'h0);
    if (k == 2'h0) sp = sp - 16'h1;
  endtask

  // Free cycles stay reads
  always @(posedge ref_clk) begin
    if (!rst && cyc_type === cyc_pkg::CYC_FREE)
      chk("free_rd", 16'h2, {14'h0, bus_rd, bus_wr});
  end

  initial begin
    #5000;
    error_cnt++;
    summarize();
  end

  initial begin
    seed = lfsr(seed);
    index_hx = {8'h02, seed[7:0]};
    repeat (20) @(posedge ref_clk);
    u_mem.mem[16'h0000] = cyc_pkg::OP_IDX_TO_SP;
    rst <= 1'b0;
    #1;
    chk("fetch0", cyc_pkg::RESET_PC, bus_addr);
    step();
    chk("xfer_cyc", {13'h0, cyc_pkg::CYC_FREE}, {13'h0, cyc_type});
    chk("xfer_imask", 16'h1, {15'h0, irq_mask});
    pc = 16'h0001;
    sp = index_hx - 16'h1;
    req(2'h0, seed[23:16]);
    req(2'h1, 8'h00);
    req(2'h2, seed[15:8]);
    req(2'h3, 8'h7f);
    req(2'h3, 8'h80);
    seed = lfsr(seed);
    req(2'h3, seed[7:0]);
    u_mem.mem[pc] = cyc_pkg::OP_WAIT_IRQ;
    u_mem.mem[16'hfff0] = 8'h12;
    u_mem.mem[16'hfff1] = 8'h34;
    step();
    chk("wait_fetch", pc, bus_addr);
    pc = pc + 16'h1;
    step();
    step();
    chk("halt", 16'h1, {15'h0, halted});
    chk("imask_clr", 16'h0, {15'h0, irq_mask});
    repeat (3) step();
    chk("still_halt", 16'h1, {15'h0, halted});
    @(posedge ref_clk);
    irq_pin <= 1'b1;
    n = 0;
    while (cyc_type !== cyc_pkg::CYC_PUSH && n < 10) begin
      step();
      n++;
    end
    chk("push_l", sp, bus_addr);
    chk("pcl", {8'h00, pc[7:0]}, {8'h00, bus_wdata});
    chk("woke", 16'h0, {15'h0, halted});
    @(posedge ref_clk);
    irq_pin <= 1'b0;
    #1;
    chk("push_h", sp - 16'h1, bus_addr);
    chk("pch", {8'h00, pc[15:8]}, {8'h00, bus_wdata});
    step();
    chk("vec_h", cyc_pkg::IRQ_VECTOR, bus_addr);
    chk("sp_irq", sp - 16'h2, stack_ptr);
    step();
    chk("vec_l", cyc_pkg::IRQ_VECTOR + 16'h1, bus_addr);
    step();
    chk("vec_fetch", 16'h1234, bus_addr);
    chk("imask_set", 16'h1, {15'h0, irq_mask});
    summarize();
  end
endmodule // tb
